// ===== port_io_pkg.sv
// Package: register map, field layout and reset values of the port block
package port_io_pkg;

  localparam logic [11:0] port_data_off     = 12'h000;
  localparam logic [11:0] direction_off     = 12'h004;
  localparam logic [11:0] pull_high_off     = 12'h008;
  localparam logic [11:0] wake_enable_off   = 12'h00c;
  localparam logic [11:0] function_sel_off  = 12'h010;
  localparam logic [11:0] power_status_off  = 12'h014;
  localparam logic [11:0] power_ctrl_off    = 12'h018;

  localparam int          pin_two_pos       = 2;
  localparam int          pin_zero_pos      = 0;
  localparam logic [7:0]  port_bits_mask    = 8'h05;
  localparam logic [7:0]  function_sel_mask = 8'h33;
  localparam int          pin_two_fn_lsb    = 4;
  localparam int          pin_zero_fn_lsb   = 0;

  localparam logic [1:0]  fn_gpio_a         = 2'h0;
  localparam logic [1:0]  fn_analog         = 2'h1;
  localparam logic [1:0]  fn_reference      = 2'h2;
  localparam logic [1:0]  fn_gpio_b         = 2'h3;

  localparam logic [7:0]  port_data_rst     = 8'h05;
  localparam logic [7:0]  direction_rst     = 8'h05;
  localparam logic [7:0]  pull_high_rst     = 8'h00;
  localparam logic [7:0]  wake_enable_rst   = 8'h00;
  localparam logic [7:0]  function_sel_rst  = 8'h00;

  typedef enum logic [1:0] {
    apb_idle   = 2'b01,
    apb_access = 2'b10
  } apb_state_t;

endpackage : port_io_pkg

// ===== port_io_top.sv
// Port top: APB register file, two pin cells and wake request
//
// Behaviour
// - Input pin read samples pin directly, no latch
// - Output latch holds until next write
// - Only bits 2 and 0; others read zero
// - Pull-high enable bit per pin
// - Pull-up only when pin is digital input
// - Wake enable bit per pin
// - Falling edge on enabled pin wakes device
// - Wake only for GPIO pin in power-down
// - Direction 1 input, 0 push-pull output
// - Output pin reads back the latch
// - Data and direction reset to ones
// - Fresh output drives high from reset latch
// - Bit set/clear is read-modify-write by software
// - Bits 5:4 select pin two function
// - Bits 1:0 select pin zero function
`timescale 1ns/1ns
`default_nettype none
module port_io_top
  import port_io_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Power-mode controller
  input  wire logic        low_power,
  output logic             wake_req,
  // Pins
  input  wire logic [2:0]  pin_i,
  output logic [2:0]       pin_o,
  output logic [2:0]       pin_oe,
  output logic [2:0]       pull_en,
  // Selected functions
  output logic [1:0]       pin_two_fn,
  output logic [1:0]       pin_zero_fn
);

  logic [7:0]  port_data_q;
  logic [7:0]  direction_q;
  logic [7:0]  pull_high_q;
  logic [7:0]  wake_enable_q;
  logic [7:0]  function_sel_q;
  logic        wake_flag_q;
  apb_state_t  state_q;
  logic [31:0] rdata_d;
  logic        addr_ok;
  logic        wr_go;
  logic        clr_wake;
  logic [2:0]  c_o;
  logic [2:0]  c_oe;
  logic [2:0]  c_pull;
  logic [2:0]  c_gpio;
  logic [2:0]  c_wake;
  logic        wake_any;

  function automatic logic [7:0] port_view(input logic [7:0] latch,
                                           input logic [7:0] dir,
                                           input logic [2:0] pins);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 3; i++) begin
      v[i] = dir[i] ? pins[i] : latch[i];
    end
    return v & port_bits_mask;
  endfunction : port_view

  function automatic logic valid_off(input logic [11:0] a);
    return (a == port_data_off) || (a == direction_off)
        || (a == pull_high_off) || (a == wake_enable_off)
        || (a == function_sel_off) || (a == power_status_off)
        || (a == power_ctrl_off);
  endfunction : valid_off

  // APB: one wait state, answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= apb_idle;
    end else begin
      unique case (state_q)
        apb_idle: begin
          if (psel && penable) state_q <= apb_access;
        end
        apb_access: begin
          state_q <= apb_idle;
        end
        default: state_q <= apb_idle;
      endcase
    end
  end

  assign addr_ok  = valid_off(paddr);
  assign wr_go    = (state_q == apb_access) && psel && penable
                    && pwrite && addr_ok;
  assign clr_wake = wr_go && (paddr == power_ctrl_off) && pwdata[0];

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      port_data_off:
        rdata_d[7:0] = port_view(port_data_q, direction_q, pin_i);
      direction_off:    rdata_d[7:0] = direction_q;
      pull_high_off:    rdata_d[7:0] = pull_high_q;
      wake_enable_off:  rdata_d[7:0] = wake_enable_q;
      function_sel_off: rdata_d[7:0] = function_sel_q;
      power_status_off: rdata_d[7:0] = {5'h00, low_power, 1'b0,
                                        wake_flag_q};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= (state_q == apb_idle) && psel && penable;
      pslverr <= (state_q == apb_idle) && psel && penable && !addr_ok;
      if ((state_q == apb_idle) && psel && penable && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // Full-word writes; software does its own read-modify-write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_q    <= port_data_rst;
      direction_q    <= direction_rst;
      pull_high_q    <= pull_high_rst;
      wake_enable_q  <= wake_enable_rst;
      function_sel_q <= function_sel_rst;
    end else if (wr_go) begin
      unique case (paddr)
        port_data_off:
          port_data_q <= pwdata[7:0] & port_bits_mask;
        direction_off:
          direction_q <= pwdata[7:0] & port_bits_mask;
        pull_high_off:
          pull_high_q <= pwdata[7:0] & port_bits_mask;
        wake_enable_off:
          wake_enable_q <= pwdata[7:0] & port_bits_mask;
        function_sel_off:
          function_sel_q <= pwdata[7:0] & function_sel_mask;
        default: begin
        end
      endcase
    end
  end

  for (genvar p = 0; p < 3; p += 2) begin : g_pin
    port_pin_cell u_cell (
      .pclk      (pclk),
      .presetn   (presetn),
      .data_bit  (port_data_q[p]),
      .dir_bit   (direction_q[p]),
      .pull_bit  (pull_high_q[p]),
      .wake_bit  (wake_enable_q[p]),
      .fn_sel    (p == pin_two_pos
                  ? function_sel_q[pin_two_fn_lsb +: 2]
                  : function_sel_q[pin_zero_fn_lsb +: 2]),
      .low_power (low_power),
      .pin_i     (pin_i[p]),
      .pin_o     (c_o[p]),
      .pin_oe    (c_oe[p]),
      .pull_en   (c_pull[p]),
      .is_gpio   (c_gpio[p]),
      .wake_hit  (c_wake[p])
    );
  end
  assign c_o[1]    = 1'b0;
  assign c_oe[1]   = 1'b0;
  assign c_pull[1] = 1'b0;
  assign c_gpio[1] = 1'b0;
  assign c_wake[1] = 1'b0;

  assign wake_any = |c_wake;

  // Sticky wake flag; a new edge beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_flag_q <= 1'b0;
      wake_req    <= 1'b0;
    end else begin
      if (wake_any) wake_flag_q <= 1'b1;
      else if (clr_wake) wake_flag_q <= 1'b0;
      wake_req <= wake_any;
    end
  end

  // Registered pin drive keeps every output on a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o       <= 3'h0;
      pin_oe      <= 3'h0;
      pull_en     <= 3'h0;
      pin_two_fn  <= 2'h0;
      pin_zero_fn <= 2'h0;
    end else begin
      pin_o       <= c_o & c_oe;
      pin_oe      <= c_oe;
      pull_en     <= c_pull;
      pin_two_fn  <= function_sel_q[pin_two_fn_lsb +: 2];
      pin_zero_fn <= function_sel_q[pin_zero_fn_lsb +: 2];
    end
  end

  a_reset_inputs: assert property (@(posedge pclk)
    $rose(presetn) |-> direction_q == direction_rst
                    && port_data_q == port_data_rst)
    else $error("Reset did not set pins as inputs");

  a_pull_gating: assert property (
    @(posedge pclk) disable iff (!presetn)
    pull_en[0] |-> $past(direction_q[0]) && $past(c_gpio[0]))
    else $error("Pull-up on while not a digital input");

  a_pull_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    pull_en[2] |-> $past(direction_q[2]) && $past(c_gpio[2]))
    else $error("Pull-up on pin two while not a digital input");

  a_wake_needs_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    wake_req |-> $past(low_power) && $past(|wake_enable_q))
    else $error("Wake request outside power-down");

  // Enable and function must hold in both cycles, else no wake is owed
  sequence s_fall_two;
    low_power && wake_enable_q[2] && c_gpio[2] && pin_i[2]
    ##1 low_power && wake_enable_q[2] && c_gpio[2] && !pin_i[2];
  endsequence

  sequence s_fall_zero;
    low_power && wake_enable_q[0] && c_gpio[0] && pin_i[0]
    ##1 low_power && wake_enable_q[0] && c_gpio[0] && !pin_i[0];
  endsequence

  a_wake_on_fall: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_fall_two |=> wake_req)
    else $error("Falling edge did not wake");

  a_wake_fall_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_fall_zero |=> wake_req)
    else $error("Falling edge on pin zero did not wake");

  a_flag_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    wake_any |=> wake_flag_q)
    else $error("Wake flag lost a qualified edge");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready stood longer than one cycle");

  a_read_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_q == apb_idle && psel && penable && !pwrite
    && paddr == port_data_off && !direction_q[0]
    |=> prdata[0] == $past(port_data_q[0]))
    else $error("Output pin read did not return latch");

  a_read_pin: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_q == apb_idle && psel && penable && !pwrite
    && paddr == port_data_off && direction_q[2]
    |=> prdata[2] == $past(pin_i[2]))
    else $error("Input pin read did not sample pin");

  a_unused_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pslverr && $past(!pwrite) && $past(paddr) == port_data_off
    |-> prdata[7:3] == 5'h00 && !prdata[1])
    else $error("Unimplemented port bit read non-zero");

  a_latch_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(wr_go) |-> $stable(port_data_q))
    else $error("Output latch changed without write");

  a_drive_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_oe[2] |-> $past(!direction_q[2])
               && pin_o[2] == $past(port_data_q[2]))
    else $error("Pin driven without output direction");

  a_drive_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_oe[0] |-> $past(!direction_q[0])
               && pin_o[0] == $past(port_data_q[0]))
    else $error("Pin zero driven without output direction");

  a_fn_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(function_sel_q[5:4]) == fn_analog |-> !pin_oe[2])
    else $error("Analog pin still driven as GPIO");

  a_ref_no_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(function_sel_q[pin_zero_fn_lsb +: 2]) == fn_reference
    |-> !pin_oe[0])
    else $error("Reference pin still driven as GPIO");

endmodule : port_io_top
`default_nettype wire

// ===== port_pin_cell.sv
// One pin: function decode, drive, pull-up and falling-edge wake
`timescale 1ns/1ns
`default_nettype none
module port_pin_cell
  import port_io_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       data_bit,
  input  wire logic       dir_bit,
  input  wire logic       pull_bit,
  input  wire logic       wake_bit,
  input  wire logic [1:0] fn_sel,
  input  wire logic       low_power,
  // Pin
  input  wire logic       pin_i,
  output logic            pin_o,
  output logic            pin_oe,
  output logic            pull_en,
  output logic            is_gpio,
  output logic            wake_hit
);

  logic pin_prev_q;

  function automatic logic gpio_sel(input logic [1:0] f);
    return (f == fn_gpio_a) || (f == fn_gpio_b);
  endfunction : gpio_sel

  always_comb begin
    is_gpio = gpio_sel(fn_sel);
    // Latch drives pin only as GPIO output
    pin_o   = data_bit;
    pin_oe  = is_gpio && !dir_bit;
    // Pull-up only for a digital input
    pull_en = pull_bit && is_gpio && dir_bit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_i;
    end
  end

  // Falling edge counts only in power-down as GPIO
  assign wake_hit = wake_bit && is_gpio && low_power
                    && pin_prev_q && !pin_i;

endmodule : port_pin_cell
`default_nettype wire

// ===== port_switch_model.sv
// Switch model: external drivers and wire level on the port pins
`timescale 1ns/1ns
`default_nettype none
module port_switch_model (
  // Clock
  input  wire logic       pclk,
  // Device side
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] pull_en,
  // Switches
  input  wire logic [2:0] sw_en,
  input  wire logic [2:0] sw_lvl,
  output logic      [2:0] pin_i
);
  logic tgl_q;
  initial tgl_q = 1'b0;
  // Undriven pin without pull-up wanders, so no stale level is read
  always @(posedge pclk) tgl_q <= ~tgl_q;
  // A commanded switch overpowers the pin driver
  always_comb begin
    for (int b = 0; b < 3; b++) begin
      if (sw_en[b]) pin_i[b] = sw_lvl[b];
      else if (pin_oe[b]) pin_i[b] = pin_o[b];
      else if (pull_en[b]) pin_i[b] = 1'b1;
      else pin_i[b] = tgl_q;
    end
  end
endmodule : port_switch_model
`default_nettype wire

// ===== tb.sv
// Testbench: port block over APB with a switch model on the pins
`timescale 1ns/1ns
`default_nettype none
module tb
  import port_io_pkg::*;
;
  typedef struct {logic [31:0] d; logic e; logic r;} exp_t;
  logic        pclk, presetn, psel, penable, pwrite, low_power;
  logic        pready, pslverr, wake_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, r;
  logic [2:0]  pin_i, pin_o, pin_oe, pull_en, sw_en, sw_lvl;
  logic [1:0]  pin_two_fn, pin_zero_fn, f;
  logic [11:0] ad[4];
  logic [7:0]  mk[4];
  exp_t        q[$];
  exp_t        e;
  int          n_fail, num_checks, i;

  port_io_top i_port_io_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .low_power, .wake_req,
    .pin_i, .pin_o, .pin_oe, .pull_en, .pin_two_fn, .pin_zero_fn);
  port_switch_model i_port_switch_model (.pclk, .pin_o, .pin_oe,
    .pull_en, .sw_en, .sw_lvl, .pin_i);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      $display("MISMATCH %s exp %h got %h", s, x, g);
      n_fail++;
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  function automatic logic gp(input logic [1:0] v);
    return v == fn_gpio_a || v == fn_gpio_b;
  endfunction : gp

  // Expected answer is queued before the transfer starts
  task automatic xf(input logic w, input logic [11:0] a,
                    input logic [31:0] d, input logic er);
    int k;
    q.push_back('{d, er, !w});
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= w ? d : 32'h0;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 1, 0);
      wrap_up();
    end
  endtask : xf

  // Falling switch edge, then count the request pulses
  task automatic wake(input int p, input logic x);
    int k, n;
    n = 0;
    sw_lvl[p] <= 1'b0;
    for (k = 0; k < 6; k++) begin
      @(posedge pclk);
      n += (wake_req === 1'b1);
    end
    chk("wake_req", x, n);
    sw_lvl[p] <= 1'b1;
    cyc(4);
  endtask : wake

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      chk("pslverr", e.e, pslverr);
      if (e.r) chk("prdata", e.d, prdata);
    end
  end

  initial begin
    cyc(100000);
    chk("timeout", 0, 1);
    wrap_up();
  end

  initial begin
    {presetn, psel, penable, pwrite, low_power} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sw_en = 3'h5;
    sw_lvl = 3'h4;
    n_fail = 0;
    num_checks = 0;
    ad = '{direction_off, pull_high_off, wake_enable_off, function_sel_off};
    mk = '{8'h05, 8'h05, 8'h05, 8'h33};
    void'($urandom(66269));
    cyc(12);
    presetn <= 1'b1;
    cyc(2);
    chk("pin_oe", 3'h0, pin_oe);
    xf(0, port_data_off, 32'h4, 0);
    xf(0, direction_off, 32'h5, 0);
    for (i = 1; i < 4; i++) xf(0, ad[i], 32'h0, 0);
    sw_en <= 3'h0;
    xf(1, direction_off, 32'h0, 0);
    cyc(2);
    chk("pin_o", 3'h5, pin_o & 3'h5);
    chk("pin_oe", 3'h5, pin_oe);
    repeat (6) begin
      r = $urandom;
      xf(1, port_data_off, r, 0);
      cyc(3);
      chk("pin_o", r[2:0] & 3'h5, pin_o & 3'h5);
      xf(0, port_data_off, r & 32'h5, 0);
    end
    sw_en <= 3'h5;
    sw_lvl <= ~r[2:0];
    xf(0, port_data_off, r & 32'h5, 0);
    for (i = 0; i < 4; i++) begin
      r = $urandom;
      xf(1, ad[i], r, 0);
      xf(0, ad[i], r & mk[i], 0);
    end
    xf(1, function_sel_off, 32'h0, 0);
    xf(1, direction_off, 32'h4, 0);
    xf(1, port_data_off, 32'h1, 0);
    sw_en <= 3'h4;
    sw_lvl <= 3'h0;
    cyc(2);
    chk("pin_oe", 3'h1, pin_oe);
    xf(0, port_data_off, 32'h1, 0);
    sw_lvl <= 3'h4;
    xf(0, port_data_off, 32'h5, 0);
    xf(0, direction_off, 32'h4, 0);
    xf(1, direction_off, rv | 32'h1, 0);
    xf(0, direction_off, 32'h5, 0);
    // Switches hold both pins high so each fall is a clean edge
    sw_en <= 3'h5;
    sw_lvl <= 3'h5;
    xf(1, pull_high_off, 32'h5, 0);
    xf(1, wake_enable_off, 32'h5, 0);
    low_power <= 1'b1;
    for (i = 0; i < 4; i++) begin
      f = i[1:0];
      xf(1, function_sel_off, {26'h0, f, 2'h0, f ^ 2'h1}, 0);
      cyc(2);
      chk("two_fn", f, pin_two_fn);
      chk("zero_fn", f ^ 2'h1, pin_zero_fn);
      chk("pull_en", {gp(f), 1'b0, gp(f ^ 2'h1)}, pull_en);
      wake(2, gp(f));
      wake(0, gp(f ^ 2'h1));
      xf(0, power_status_off, 32'h5, 0);
      xf(1, power_ctrl_off, 32'h1, 0);
    end
    xf(0, power_status_off, 32'h4, 0);
    xf(1, function_sel_off, 32'h0, 0);
    xf(1, direction_off, 32'h0, 0);
    cyc(2);
    chk("pull_en", 3'h0, pull_en);
    xf(1, direction_off, 32'h5, 0);
    low_power <= 1'b0;
    cyc(2);
    wake(0, 0);
    low_power <= 1'b1;
    xf(1, wake_enable_off, 32'h1, 0);
    wake(2, 0);
    wake(0, 1);
    xf(1, 12'h01c, 32'hff, 1);
    xf(0, 12'h01c, 32'h0, 1);
    cyc(2);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
